// file: include/sid_pkg.sv
// constants, types and field layout for the subtract decode/execute block
// assumes a 16-bit first opcode word and one optional extension word
package sid_pkg;
   // opcode field layout
   localparam int OP_LINE_HI = 15;
   localparam int OP_LINE_LO = 12;
   localparam logic [3:0] OP_LINE_SUB = 4'h9;
   localparam int OP_REG_HI = 11;
   localparam int OP_REG_LO = 9;
   localparam int OP_MODE_HI = 8;
   localparam int OP_MODE_LO = 6;
   localparam int OP_EAM_HI = 5;
   localparam int OP_EAM_LO = 3;
   localparam int OP_EAR_HI = 2;
   localparam int OP_EAR_LO = 0;
   // operation-mode codes
   localparam logic [2:0] OPM_DN_B = 3'h0;
   localparam logic [2:0] OPM_DN_W = 3'h1;
   localparam logic [2:0] OPM_DN_L = 3'h2;
   localparam logic [2:0] OPM_AN_W = 3'h3;
   localparam logic [2:0] OPM_EA_B = 3'h4;
   localparam logic [2:0] OPM_EA_W = 3'h5;
   localparam logic [2:0] OPM_EA_L = 3'h6;
   localparam logic [2:0] OPM_AN_L = 3'h7;
   // effective-address mode and register codes
   localparam logic [2:0] EAM_DREG = 3'h0;
   localparam logic [2:0] EAM_AREG = 3'h1;
   localparam logic [2:0] EAM_IND = 3'h2;
   localparam logic [2:0] EAM_POSTINC = 3'h3;
   localparam logic [2:0] EAM_PREDEC = 3'h4;
   localparam logic [2:0] EAM_DISP = 3'h5;
   localparam logic [2:0] EAM_INDEX = 3'h6;
   localparam logic [2:0] EAM_EXT = 3'h7;
   localparam logic [2:0] EAR_ABS_W = 3'h0;
   localparam logic [2:0] EAR_ABS_L = 3'h1;
   localparam logic [2:0] EAR_PC_DISP = 3'h2;
   localparam logic [2:0] EAR_PC_INDEX = 3'h3;
   localparam logic [2:0] EAR_IMM = 3'h4;
   // extension word bit that marks the full index format
   localparam int EXT_FULL_BIT = 8;
   // condition flag positions in the flag vector
   localparam int CC_C = 0;
   localparam int CC_V = 1;
   localparam int CC_Z = 2;
   localparam int CC_N = 3;
   localparam int CC_X = 4;
   localparam logic [4:0] CC_RESET = 5'h00;
   localparam logic [31:0] WORD_RESET = 32'h0000_0000;
   localparam int NUM_REGS = 8;

   typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} sid_size_t;

   typedef enum logic [3:0] {
      EK_DATA_REG, EK_ADDR_REG, EK_IND, EK_POSTINC, EK_PREDEC, EK_DISP,
      EK_BRIEF_IDX, EK_FULL_IDX, EK_ABS_W, EK_ABS_L, EK_PC_DISP,
      EK_PC_BRIEF, EK_PC_FULL, EK_IMM, EK_BAD
   } sid_ea_t;
endpackage : sid_pkg

// file: logic/sid_core.sv
// decode and execute of the general and address-register subtract forms
// assumes memory operands are fetched outside and arrive with the opcode
// How it works
// RQ1: difference is destination minus source, sized
// RQ2: extend flag copies the carry flag
// RQ3: negative flag is sized result msb
// RQ4: zero flag when sized result is zero
// RQ5: overflow flag on signed sized overflow
// RQ6: carry flag on unsigned borrow out
// RQ7: opmodes 000-010 write data register
// RQ8: opmodes 100-110 write effective address
// RQ9: register field picks one data register
// RQ10: every source addressing mode is accepted; the code refuses an address register source at byte size
// RQ11: address register source illegal at byte
// RQ12: destination must be memory alterable
// RQ13: software never encodes data destination as address
// RQ14: address form writes register, flags untouched
// RQ15: opmode 011 sign-extends word, 111 long
// RQ16: register field picks one address register
// RQ17: address form takes every source mode
// RQ18: absolute short 111/000, long 111/001
// RQ19: line 1001, reg, opmode, ea fields
// RQ20: extension word splits brief from full index
`timescale 1ns/1ps
`default_nettype none
module sid_core
   import sid_pkg::*;
(
   input wire logic CLK,
   input wire logic RST,
   input wire logic INSN_VALID,
   input wire logic [15:0] OPCODE,
   input wire logic [15:0] EXT_WORD,
   input wire logic [31:0] EA_DATA,
   input wire logic REG_LOAD,
   input wire logic [3:0] REG_SEL,
   input wire logic [31:0] REG_DATA,
   output logic DONE,
   output logic ILLEGAL,
   output logic MEM_WR,
   output logic [31:0] MEM_DATA,
   output sid_pkg::sid_size_t MEM_SIZE,
   output sid_pkg::sid_ea_t EA_KIND,
   output logic [31:0] RESULT,
   output logic FLAG_X,
   output logic FLAG_N,
   output logic FLAG_Z,
   output logic FLAG_V,
   output logic FLAG_C,
   output logic [31:0] OBS_DATA
);
   import sid_pkg::*;

   // ==========================================================
   // helpers
   function automatic logic [31:0] size_mask(input sid_size_t sz);
      case (sz)
         SZ_BYTE: size_mask = 32'h0000_00FF;
         SZ_WORD: size_mask = 32'h0000_FFFF;
         default: size_mask = 32'hFFFF_FFFF;
      endcase
   endfunction : size_mask

   function automatic logic msb_of(input logic [31:0] v, input sid_size_t sz);
      case (sz)
         SZ_BYTE: msb_of = v[7];
         SZ_WORD: msb_of = v[15];
         default: msb_of = v[31];
      endcase
   endfunction : msb_of

   // returns {c, v, z, n, result}; operands masked so the borrow sits just above size
   function automatic logic [35:0] sub_sized(input logic [31:0] d, input logic [31:0] s,
                                             input sid_size_t sz);
      logic [31:0] m;
      logic [32:0] diff;
      logic [31:0] r;
      logic brw;
      logic ovf;
      m = size_mask(sz);
      diff = {1'b0, d & m} - {1'b0, s & m};
      r = diff[31:0] & m;
      case (sz)
         SZ_BYTE: brw = diff[8];
         SZ_WORD: brw = diff[16];
         default: brw = diff[32];
      endcase
      ovf = (msb_of(d, sz) != msb_of(s, sz)) && (msb_of(r, sz) != msb_of(d, sz));
      sub_sized = {brw, ovf, (r == 32'h0000_0000), msb_of(r, sz), r};
   endfunction : sub_sized

   // ==========================================================
   // decode
   logic [2:0] f_reg;
   logic [2:0] f_opm;
   logic [2:0] f_eam;
   logic [2:0] f_ear;
   logic is_line;
   logic is_addr_form;
   logic ea_is_dest;
   sid_size_t op_size;
   sid_ea_t ea_kind;
   logic bad_ea;

   always_comb begin
      is_line = (OPCODE[OP_LINE_HI:OP_LINE_LO] == OP_LINE_SUB); // RQ19
      f_reg = OPCODE[OP_REG_HI:OP_REG_LO];
      f_opm = OPCODE[OP_MODE_HI:OP_MODE_LO];
      f_eam = OPCODE[OP_EAM_HI:OP_EAM_LO];
      f_ear = OPCODE[OP_EAR_HI:OP_EAR_LO];
      is_addr_form = (f_opm == OPM_AN_W) || (f_opm == OPM_AN_L);
      ea_is_dest = f_opm[2] && !is_addr_form;
      case (f_opm)
         OPM_DN_B, OPM_EA_B: op_size = SZ_BYTE;
         OPM_DN_W, OPM_EA_W, OPM_AN_W: op_size = SZ_WORD; // RQ15
         default: op_size = SZ_LONG;
      endcase
      case (f_eam)
         EAM_DREG: ea_kind = EK_DATA_REG;
         EAM_AREG: ea_kind = EK_ADDR_REG;
         EAM_IND: ea_kind = EK_IND;
         EAM_POSTINC: ea_kind = EK_POSTINC;
         EAM_PREDEC: ea_kind = EK_PREDEC;
         EAM_DISP: ea_kind = EK_DISP;
         EAM_INDEX: ea_kind = EXT_WORD[EXT_FULL_BIT] ? EK_FULL_IDX : EK_BRIEF_IDX; // RQ20
         default: begin
            case (f_ear)
               EAR_ABS_W: ea_kind = EK_ABS_W; // RQ18
               EAR_ABS_L: ea_kind = EK_ABS_L; // RQ18
               EAR_PC_DISP: ea_kind = EK_PC_DISP;
               EAR_PC_INDEX: ea_kind = EXT_WORD[EXT_FULL_BIT] ? EK_PC_FULL : EK_PC_BRIEF; // RQ20
               EAR_IMM: ea_kind = EK_IMM;
               default: ea_kind = EK_BAD;
            endcase
         end
      endcase
      if (ea_kind == EK_BAD) begin
         bad_ea = 1'b1;
      end else if (ea_is_dest) begin
         // only memory alterable kinds survive as a destination
         bad_ea = (ea_kind == EK_DATA_REG) || (ea_kind == EK_ADDR_REG) ||
                  (ea_kind == EK_IMM) || (ea_kind == EK_PC_DISP) ||
                  (ea_kind == EK_PC_BRIEF) || (ea_kind == EK_PC_FULL); // RQ12
      end else if (!is_addr_form) begin
         bad_ea = (ea_kind == EK_ADDR_REG) && (op_size == SZ_BYTE); // RQ10 RQ11
      end else begin
         bad_ea = 1'b0; // RQ17
      end
   end

   // ==========================================================
   // execute
   logic [31:0] dreg_r [NUM_REGS];
   logic [31:0] areg_r [NUM_REGS];
   logic [31:0] dreg_nxt [NUM_REGS];
   logic [31:0] areg_nxt [NUM_REGS];
   logic [4:0] cc_r;
   logic [4:0] cc_nxt;
   logic done_r, done_nxt;
   logic ill_r, ill_nxt;
   logic mwr_r, mwr_nxt;
   logic [31:0] mdata_r, mdata_nxt;
   sid_size_t msize_r, msize_nxt;
   sid_ea_t kind_r, kind_nxt;
   logic [31:0] res_r, res_nxt;
   logic [31:0] obs_r, obs_nxt;
   logic [31:0] src_val;
   logic [31:0] dst_val;
   logic [35:0] alu;

   always_comb begin
      for (int i = 0; i < NUM_REGS; i++) begin
         dreg_nxt[i] = dreg_r[i];
         areg_nxt[i] = areg_r[i];
      end
      cc_nxt = cc_r;
      done_nxt = 1'b0;
      ill_nxt = 1'b0;
      mwr_nxt = 1'b0;
      mdata_nxt = mdata_r;
      msize_nxt = msize_r;
      kind_nxt = kind_r;
      res_nxt = res_r;
      // register-direct sources come from our own files, everything else is fetched
      case (ea_kind)
         EK_DATA_REG: src_val = dreg_r[f_ear];
         EK_ADDR_REG: src_val = areg_r[f_ear];
         default: src_val = EA_DATA;
      endcase
      if (is_addr_form) begin
         dst_val = areg_r[f_reg]; // RQ16
         if (op_size == SZ_WORD) begin
            src_val = {{16{src_val[15]}}, src_val[15:0]}; // RQ15
         end
         alu = sub_sized(dst_val, src_val, SZ_LONG); // RQ15
      end else if (ea_is_dest) begin
         dst_val = EA_DATA;
         alu = sub_sized(dst_val, dreg_r[f_reg], op_size); // RQ8 RQ9
      end else begin
         dst_val = dreg_r[f_reg]; // RQ9
         alu = sub_sized(dst_val, src_val, op_size); // RQ1 RQ7
      end
      if (INSN_VALID && is_line) begin
         kind_nxt = ea_kind;
         if (bad_ea) begin
            // refused without touching registers or flags
            ill_nxt = 1'b1;
         end else begin
            done_nxt = 1'b1;
            res_nxt = alu[31:0];
            if (is_addr_form) begin
               areg_nxt[f_reg] = alu[31:0]; // RQ14
            end else begin
               cc_nxt[CC_C] = alu[35]; // RQ6
               cc_nxt[CC_V] = alu[34]; // RQ5
               cc_nxt[CC_Z] = alu[33]; // RQ4
               cc_nxt[CC_N] = alu[32]; // RQ3
               cc_nxt[CC_X] = alu[35]; // RQ2
               if (ea_is_dest) begin
                  mwr_nxt = 1'b1; // RQ8
                  mdata_nxt = alu[31:0];
                  msize_nxt = op_size;
               end else begin
                  // upper bits of the data register are kept at byte and word size
                  dreg_nxt[f_reg] = (dreg_r[f_reg] & ~size_mask(op_size)) | alu[31:0]; // RQ7
               end
            end
         end
      end else if (REG_LOAD) begin
         // preload port; loses to a subtract in the same cycle
         if (REG_SEL[3]) begin
            areg_nxt[REG_SEL[2:0]] = REG_DATA;
         end else begin
            dreg_nxt[REG_SEL[2:0]] = REG_DATA;
         end
      end
      obs_nxt = REG_SEL[3] ? areg_nxt[REG_SEL[2:0]] : dreg_nxt[REG_SEL[2:0]];
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         for (int i = 0; i < NUM_REGS; i++) begin
            dreg_r[i] <= WORD_RESET;
            areg_r[i] <= WORD_RESET;
         end
         cc_r <= CC_RESET;
         done_r <= 1'b0;
         ill_r <= 1'b0;
         mwr_r <= 1'b0;
         mdata_r <= WORD_RESET;
         msize_r <= SZ_BYTE;
         kind_r <= EK_DATA_REG;
         res_r <= WORD_RESET;
         obs_r <= WORD_RESET;
      end else begin
         for (int i = 0; i < NUM_REGS; i++) begin
            dreg_r[i] <= dreg_nxt[i];
            areg_r[i] <= areg_nxt[i];
         end
         cc_r <= cc_nxt;
         done_r <= done_nxt;
         ill_r <= ill_nxt;
         mwr_r <= mwr_nxt;
         mdata_r <= mdata_nxt;
         msize_r <= msize_nxt;
         kind_r <= kind_nxt;
         res_r <= res_nxt;
         obs_r <= obs_nxt;
      end
   end

   assign DONE = done_r;
   assign ILLEGAL = ill_r;
   assign MEM_WR = mwr_r;
   assign MEM_DATA = mdata_r;
   assign MEM_SIZE = msize_r;
   assign EA_KIND = kind_r;
   assign RESULT = res_r;
   assign FLAG_X = cc_r[CC_X];
   assign FLAG_N = cc_r[CC_N];
   assign FLAG_Z = cc_r[CC_Z];
   assign FLAG_V = cc_r[CC_V];
   assign FLAG_C = cc_r[CC_C];
   assign OBS_DATA = obs_r;

   // ==========================================================
   // assertions
   logic gen_done_r;
   logic [1:0] size_seen_r;
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         gen_done_r <= 1'b0;
         size_seen_r <= 2'h0;
      end else begin
         gen_done_r <= INSN_VALID && is_line && !bad_ea && !is_addr_form;
         size_seen_r <= op_size;
      end
   end

   sequence s_take_sub;
      INSN_VALID && is_line;
   endsequence
   sequence s_take_legal_general;
      s_take_sub ##0 (!bad_ea && !is_addr_form);
   endsequence

   property p_x_follows_c;
      @(posedge CLK) disable iff (RST) gen_done_r |-> FLAG_X == FLAG_C;
   endproperty
   a_x_follows_c: assert property (p_x_follows_c) else $error("x differs from c"); // RQ2

   property p_zero_flag;
      @(posedge CLK) disable iff (RST) gen_done_r |-> FLAG_Z == (RESULT == 32'h0000_0000);
   endproperty
   a_zero_flag: assert property (p_zero_flag) else $error("z mismatch"); // RQ4

   property p_neg_flag;
      @(posedge CLK) disable iff (RST)
         gen_done_r |-> FLAG_N == msb_of(RESULT, sid_size_t'(size_seen_r));
   endproperty
   a_neg_flag: assert property (p_neg_flag) else $error("n mismatch"); // RQ3

   property p_addr_form_keeps_flags;
      @(posedge CLK) disable iff (RST)
         s_take_sub ##0 (is_addr_form && !bad_ea) |=>
            DONE && $stable({FLAG_X, FLAG_N, FLAG_Z, FLAG_V, FLAG_C});
   endproperty
   a_addr_form_keeps_flags: assert property (p_addr_form_keeps_flags) else $error("flags moved"); // RQ14

   property p_dest_imm_refused;
      @(posedge CLK) disable iff (RST)
         s_take_sub ##0 (ea_is_dest && f_eam == EAM_EXT && f_ear == EAR_IMM) |=> ILLEGAL && !MEM_WR;
   endproperty
   a_dest_imm_refused: assert property (p_dest_imm_refused) else $error("imm dest taken"); // RQ12

   property p_byte_areg_refused;
      @(posedge CLK) disable iff (RST)
         s_take_sub ##0 (f_opm == OPM_DN_B && f_eam == EAM_AREG) |=> ILLEGAL && !DONE;
   endproperty
   a_byte_areg_refused: assert property (p_byte_areg_refused) else $error("byte an taken"); // RQ11

   property p_dreg_dest;
      @(posedge CLK) disable iff (RST)
         s_take_legal_general ##0 !f_opm[2] |=> DONE && !MEM_WR ##1 (!DONE || $past(INSN_VALID));
   endproperty
   a_dreg_dest: assert property (p_dreg_dest) else $error("data dest wrong"); // RQ7

   property p_mem_dest;
      @(posedge CLK) disable iff (RST)
         s_take_legal_general ##0 f_opm[2] |=> MEM_WR && MEM_DATA == RESULT;
   endproperty
   a_mem_dest: assert property (p_mem_dest) else $error("mem write missing"); // RQ8

   property p_abs_long_source;
      @(posedge CLK) disable iff (RST)
         s_take_sub ##0 (f_eam == EAM_EXT && f_ear == EAR_ABS_L) |=> EA_KIND == EK_ABS_L;
   endproperty
   a_abs_long_source: assert property (p_abs_long_source) else $error("abs long kind"); // RQ18
endmodule : sid_core
`default_nettype wire

// file: tb/tb_top.sv
// self-checking bench for the subtract decode/execute core, with a behavioural model
// assumes sid_pkg and sid_core are compiled first; one 250 MHz clock, no partner
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import sid_pkg::*;
   // ==========================================
   // signals and model state
   logic clk, rst, iv, rl, done, ill, mwr, fx, fn, fz, fv, fc;
   logic [15:0] opc, ext;
   logic [31:0] ead, rd, mdat, res, obs, m_res;
   logic [3:0] rs;
   sid_size_t msz;
   sid_ea_t kind, m_kind;
   logic [31:0] m_reg [16];
   logic [4:0] m_cc;
   int n_mismatch, cmp_count, i;
   int seed = 58479;

   sid_core sid_core_inst (.CLK(clk), .RST(rst), .INSN_VALID(iv), .OPCODE(opc), .EXT_WORD(ext),
      .EA_DATA(ead), .REG_LOAD(rl), .REG_SEL(rs), .REG_DATA(rd), .DONE(done), .ILLEGAL(ill),
      .MEM_WR(mwr), .MEM_DATA(mdat), .MEM_SIZE(msz), .EA_KIND(kind), .RESULT(res),
      .FLAG_X(fx), .FLAG_N(fn), .FLAG_Z(fz), .FLAG_V(fv), .FLAG_C(fc), .OBS_DATA(obs));

   // ==========================================
   // compare and closing tasks
   task automatic chk_w(input string nm, input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error t=%0t %s got %h exp %h", $time, nm, got, exp);
      end
   endtask : chk_w
   task automatic chk_b(input string nm, input logic got, input logic exp);
      chk_w(nm, {31'h0, got}, {31'h0, exp});
   endtask : chk_b
   task automatic chk_k(input sid_ea_t got, input sid_ea_t exp);
      chk_w("ea kind", {28'h0, got}, {28'h0, exp});
   endtask : chk_k
   task automatic chk_s(input sid_size_t got, input sid_size_t exp);
      chk_w("mem size", {30'h0, got}, {30'h0, exp});
   endtask : chk_s
   task automatic chk_cc();
      chk_b("flag x", fx, m_cc[CC_X]);
      chk_b("flag n", fn, m_cc[CC_N]);
      chk_b("flag z", fz, m_cc[CC_Z]);
      chk_b("flag v", fv, m_cc[CC_V]);
      chk_b("flag c", fc, m_cc[CC_C]);
   endtask : chk_cc
   task automatic close_out();
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : close_out

   // ==========================================
   // model and drivers
   function automatic logic [31:0] rnd();
      return $random(seed);
   endfunction : rnd
   function automatic sid_ea_t kind_of(input logic [2:0] md, input logic [2:0] rr, input logic f);
      sid_ea_t t7 [8] = '{EK_ABS_W, EK_ABS_L, EK_PC_DISP, EK_PC_BRIEF, EK_IMM, EK_BAD, EK_BAD,
         EK_BAD};
      if (md == EAM_INDEX) return f ? EK_FULL_IDX : EK_BRIEF_IDX;
      if (md != EAM_EXT) return sid_ea_t'({1'b0, md});
      if (rr == EAR_PC_INDEX && f) return EK_PC_FULL;
      return t7[rr];
   endfunction : kind_of
   task automatic do_reset();
      rst = 1;
      repeat (16) @(negedge clk);
      for (int j = 0; j < 16; j++) m_reg[j] = WORD_RESET;
      m_cc = CC_RESET;
      m_res = WORD_RESET;
      m_kind = EK_DATA_REG;
      chk_b("done", done, 1'b0);
      chk_w("result", res, m_res);
      chk_k(kind, m_kind);
      chk_cc();
      rst = 0;
   endtask : do_reset
   task automatic load(input logic [3:0] sel, input logic [31:0] v);
      rl = 1;
      rs = sel;
      rd = v;
      @(negedge clk);
      m_reg[sel] = v;
   endtask : load
   task automatic peek_all(input string nm);
      for (int j = 0; j < 16; j++) begin
         rl = 0;
         rs = j[3:0];
         @(negedge clk);
         chk_w("register", obs, m_reg[j]);
      end
      $display("test %s done", nm);
   endtask : peek_all
   // one instruction; keep leaves the valid line up so the next one follows back to back
   task automatic run(input logic [15:0] op, input logic [15:0] ex, input logic [31:0] ea,
                      input bit keep);
      logic [2:0] rg, om;
      logic [31:0] mask, d, s;
      sid_ea_t k;
      logic taken, bad, ok, st;
      int w;
      k = kind_of(op[5:3], op[2:0], ex[EXT_FULL_BIT]);
      taken = (op[OP_LINE_HI:OP_LINE_LO] == OP_LINE_SUB);
      rg = op[11:9];
      om = op[8:6];
      st = om[2] && om[1:0] != 2'h3;
      bad = (k == EK_BAD) || (om == OPM_DN_B && k == EK_ADDR_REG);
      if (st) bad = bad || k inside {EK_DATA_REG, EK_ADDR_REG, EK_PC_DISP, EK_PC_BRIEF,
         EK_PC_FULL, EK_IMM};
      ok = taken && !bad;
      s = (k == EK_DATA_REG) ? m_reg[op[2:0]] : (k == EK_ADDR_REG) ? m_reg[{1'b1, op[2:0]}] : ea;
      if (taken) m_kind = k;
      if (ok && om[1:0] == 2'h3) begin
         if (!om[2]) s = {{16{s[15]}}, s[15:0]};
         m_res = m_reg[{1'b1, rg}] - s;
         m_reg[{1'b1, rg}] = m_res;
      end else if (ok) begin
         d = st ? ea : m_reg[rg];
         if (st) s = m_reg[rg];
         w = 8 << om[1:0];
         mask = 32'hFFFF_FFFF >> (32 - w);
         d = d & mask;
         s = s & mask;
         m_res = (d - s) & mask;
         m_cc[CC_C] = s > d;
         m_cc[CC_X] = s > d;
         m_cc[CC_N] = m_res[w-1];
         m_cc[CC_Z] = (m_res == 32'h0);
         m_cc[CC_V] = (d[w-1] != s[w-1]) && (m_res[w-1] != d[w-1]);
         if (!st) m_reg[rg] = (m_reg[rg] & ~mask) | m_res;
      end
      iv = 1;
      opc = op;
      ext = ex;
      ead = ea;
      @(negedge clk);
      chk_b("done", done, ok);
      chk_b("illegal", ill, taken && bad);
      chk_b("mem write", mwr, ok && st);
      if (ok && st) chk_w("mem data", mdat, m_res);
      if (ok && st) chk_s(msz, sid_size_t'(om[1:0]));
      chk_w("result", res, m_res);
      chk_k(kind, m_kind);
      chk_cc();
      if (!keep) begin
         iv = 0;
         @(negedge clk);
      end
   endtask : run

   // ==========================================
   // clock, watchdog and test sequence
   initial begin
      clk = 0;
      forever #2 clk = ~clk;
   end
   initial begin
      #60000;
      n_mismatch++;
      close_out();
   end
   initial begin
      rst = 1;
      iv = 0;
      rl = 0;
      rs = 4'h0;
      rd = 32'h0;
      opc = 16'h0;
      ext = 16'h0;
      ead = 32'h0;
      do_reset();
      for (i = 0; i < 16; i++) load(i[3:0], rnd());
      peek_all("preload");
      load(4'h1, 32'h0000_0005);
      rl = 0;
      run(16'h9201, 16'h0, 32'h0, 0);
      run(16'h9310, 16'h0, 32'h0000_0003, 0);
      $display("test walk done");
      // every opmode, ea mode and ea register, both index formats at random
      for (i = 0; i < 512; i++) run({4'h9, 12'(rnd() & 32'h0E00) | {3'h0, i[8:0]}}, 16'(rnd()),
         rnd(), 0);
      peek_all("decode sweep");
      // back to back, with the odd foreign opcode that must be ignored
      for (i = 0; i < 300; i++) begin
         opc = 16'(rnd());
         run({(rnd() & 32'h7) != 0 ? OP_LINE_SUB : 4'(rnd() & 32'h7), opc[11:0]}, 16'(rnd()),
             rnd(), i < 299);
      end
      peek_all("back to back");
      // a preload offered together with a taken subtract is dropped
      rl = 1;
      rs = 4'h2;
      rd = rnd();
      run(16'h9442, 16'h0, 32'h0, 1);
      rl = 0;
      iv = 0;
      @(negedge clk);
      peek_all("load collision");
      do_reset();
      peek_all("second reset");
      for (i = 0; i < 40; i++) run({4'h9, 12'(rnd())}, 16'(rnd()), rnd(), 0);
      peek_all("after reset");
      close_out();
   end
endmodule : tb_top
`default_nettype wire
